// ---- regbuf_pkg.sv ----
// Package for the registered command/address buffer with parity.
// Assumes a single system clock that stands for the differential clock.
package regbuf_pkg;
   localparam int CA_W        = 22;  // Chip-select gated command/address
   localparam int CKE_W       = 2;   // Clock enable lines
   localparam int ODT_W       = 2;   // Termination control lines
   localparam int CS_W        = 4;   // Chip select inputs
   localparam int ERR_HOLD    = 2;   // Cycles the error stays low
   localparam int QUIET_CYC   = 3;   // Error held inactive after reset
   localparam logic [1:0] QUIET_CNT_W1 = 2'h3;
   localparam logic [CA_W-1:0] CA_RST = 22'h000000;
endpackage : regbuf_pkg

// ---- parity_err.sv ----
// Parity checker and open-drain error stretcher.
// Assumes data and chip-select levels already synchronised by the caller.
`timescale 1ns/1ps
module parity_err (
   input  wire logic                        clk_sys,
   input  wire logic                        arst_n,
   input  wire logic [regbuf_pkg::CA_W-1:0] ca_prev,
   input  wire logic                        cs_prev_any,
   input  wire logic                        par_bit,
   output logic                             err_oe
);
   import regbuf_pkg::*;

   logic       chk_ff;     // Compare result, two cycles before output
   logic       rep_ff;     // Extra report stage for output alignment
   logic [1:0] hold_ff;    // Remaining low cycles of the error
   logic [1:0] quiet_ff;   // Post-reset quiet counter
   logic       nxt_chk;
   wire        mismatch;
   wire        quiet;

   // Odd count of high inputs plus the parity bit is an error
   assign mismatch = ^{ca_prev, par_bit};
   assign quiet    = (quiet_ff != 2'h0);
   // Only evaluate when any select was low with the covered data
   assign nxt_chk  = cs_prev_any & mismatch;

   // Quiet window after reset release keeps the output released
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) quiet_ff <= QUIET_CNT_W1;
      else if (quiet) quiet_ff <= quiet_ff - 2'h1;
   end

   // Compare, report delay, then stretch: error one cycle later than
   // the basic compare, so it lines up with re-driven command timing
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         chk_ff  <= 1'b0;
         rep_ff  <= 1'b0;
         hold_ff <= 2'h0;
      end else begin
         chk_ff <= nxt_chk & ~quiet;
         rep_ff <= chk_ff;
         if (rep_ff)
            hold_ff <= 2'(ERR_HOLD);
         else if (hold_ff != 2'h0)
            hold_ff <= hold_ff - 2'h1;
      end
   end

   // Enable high pulls the shared line low; otherwise released
   assign err_oe = (hold_ff != 2'h0);

   a_err_hold_two: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $rose(err_oe) |-> err_oe[*2])
      else $error("error output not held for two cycles");
   a_quiet_after_rst: assert property (@(posedge clk_sys)
      $rose(arst_n) |-> !err_oe[*3])
      else $error("error reported during quiet window");
   a_err_latency: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (nxt_chk && !quiet && !err_oe) |-> ##3 err_oe)
      else $error("error not reported three cycles after compare");
endmodule : parity_err

// ---- regbuf_top.sv ----
// Registered 1:2 command/address buffer with chip-select gating and parity.
// Assumes clk_sys is the crossing of the differential clock pair; inputs
// come from the controller on that clock so they are not re-synchronised.
//
// Overview of operation
// - Sample every input on the rising clock; outputs hold in between.
// - Each registered command/address, select, clock enable and termination bit drives two identical output copies.
// - Gating on and all four selects high: command/address outputs hold.
// - Gating enable low: command/address outputs update every clock.
// - Selects 0 and 1 are re-driven; selects 2 and 3 only gate.
// - Select, clock enable and termination outputs update every clock.
// - Reset clears all registers except the quiet counter, which loads 3, and drives every output except error low.
// - Reset acts asynchronously to the clock.
// - Reset beats select control; error output is released during reset.
// - During reset clock and data inputs are ignored.
// - Leaving reset with low inputs keeps outputs low without glitches.
// - Error when high covered inputs plus parity bit count is odd.
// - Parity bit arrives one cycle after data; paired with that data.
// - Parity checked only when some select was low; else no new error is raised.
// - Parity checking ignores the gating enable.
// - An asserted error stays low two cycles or until reset.
// - Error output is active low and open drain.
// - Error reported one extra cycle after the basic compare.
// - After reset the error output stays released for three cycles.
`timescale 1ns/1ps
module regbuf_top (
   input  wire logic                         clk_sys,
   input  wire logic                         arst_n,
   input  wire logic [regbuf_pkg::CA_W-1:0]  cmd_addr_in,
   input  wire logic                         chip_sel_in_0_n,
   input  wire logic                         chip_sel_in_1_n,
   input  wire logic                         chip_sel_in_2_n,
   input  wire logic                         chip_sel_in_3_n,
   input  wire logic [regbuf_pkg::CKE_W-1:0] clock_enable_in,
   input  wire logic [regbuf_pkg::ODT_W-1:0] termination_ctl_in,
   input  wire logic                         select_gating_enable,
   input  wire logic                         parity_bit_in,
   output logic      [regbuf_pkg::CA_W-1:0]  cmd_addr_out_a,
   output logic      [regbuf_pkg::CA_W-1:0]  cmd_addr_out_b,
   output logic                              chip_sel_out_0_n_a,
   output logic                              chip_sel_out_0_n_b,
   output logic                              chip_sel_out_1_n_a,
   output logic                              chip_sel_out_1_n_b,
   output logic      [regbuf_pkg::CKE_W-1:0] clock_enable_out_a,
   output logic      [regbuf_pkg::CKE_W-1:0] clock_enable_out_b,
   output logic      [regbuf_pkg::ODT_W-1:0] termination_ctl_out_a,
   output logic      [regbuf_pkg::ODT_W-1:0] termination_ctl_out_b,
   output logic                              parity_error_n_o,
   output logic                              parity_error_n_oe
);
   import regbuf_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Registers
   logic [CA_W-1:0]  ca_ff;       // Gated command/address latch
   logic [1:0]       cs_ff;       // Re-driven selects 0 and 1
   logic [CKE_W-1:0] cke_ff;
   logic [ODT_W-1:0] odt_ff;
   logic [CA_W-1:0]  ca_par_ff;   // Raw data kept for late parity
   logic             csv_ff;      // Some select was low with that data
   logic [CA_W-1:0]  nxt_ca;

   wire [CS_W-1:0] cs_all;
   wire            cs_any_low;
   wire            ca_update;
   wire            err_oe;

   ////////////////////////////////////////////////////////////////////////
   // Decode: gating holds the latch only when every select is high
   assign cs_all     = {chip_sel_in_3_n, chip_sel_in_2_n,
                        chip_sel_in_1_n, chip_sel_in_0_n};
   assign cs_any_low = ~&cs_all;
   assign ca_update  = ~select_gating_enable | cs_any_low;
   assign nxt_ca     = ca_update ? cmd_addr_in : ca_ff;

   // Command/address latch; reset wins over any select state
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) ca_ff <= CA_RST;
      else ca_ff <= nxt_ca;
   end

   // Ungated controls re-register every clock
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cs_ff  <= 2'h0;
         cke_ff <= '0;
         odt_ff <= '0;
      end else begin
         cs_ff  <= {chip_sel_in_1_n, chip_sel_in_0_n};
         cke_ff <= clock_enable_in;
         odt_ff <= termination_ctl_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Parity side: raw data is kept even while gated, since the
   // checker must see what the controller sent, not what was held.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ca_par_ff <= CA_RST;
         csv_ff    <= 1'b0;
      end else begin
         ca_par_ff <= cmd_addr_in;
         csv_ff    <= cs_any_low;
      end
   end

   parity_err parity_err_inst (
      .clk_sys     (clk_sys),
      .arst_n      (arst_n),
      .ca_prev     (ca_par_ff),
      .cs_prev_any (csv_ff),
      .par_bit     (parity_bit_in),
      .err_oe      (err_oe)
   );

   ////////////////////////////////////////////////////////////////////////
   // Two copies of every re-driven command/address and control bit
   assign cmd_addr_out_a        = ca_ff;
   assign cmd_addr_out_b        = ca_ff;
   assign chip_sel_out_0_n_a    = cs_ff[0];
   assign chip_sel_out_0_n_b    = cs_ff[0];
   assign chip_sel_out_1_n_a    = cs_ff[1];
   assign chip_sel_out_1_n_b    = cs_ff[1];
   assign clock_enable_out_a    = cke_ff;
   assign clock_enable_out_b    = cke_ff;
   assign termination_ctl_out_a = odt_ff;
   assign termination_ctl_out_b = odt_ff;
   // Open drain: the output level is always low, only the enable moves
   assign parity_error_n_o      = 1'b0;
   assign parity_error_n_oe     = err_oe;

   ////////////////////////////////////////////////////////////////////////
   sequence s_gated_idle;
      select_gating_enable && (&cs_all);
   endsequence

   a_gate_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_gated_idle |=> $stable(cmd_addr_out_a))
      else $error("outputs changed while gated");
   a_nogate_upd: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !select_gating_enable |=> cmd_addr_out_a == $past(cmd_addr_in))
      else $error("outputs not updated with gating off");
   a_copies_match: assert property (@(posedge clk_sys)
      cmd_addr_out_a == cmd_addr_out_b)
      else $error("output copies differ");
   a_ctl_redrive: assert property (@(posedge clk_sys) disable iff (!arst_n)
      1'b1 |=> clock_enable_out_a == $past(clock_enable_in) &&
      chip_sel_out_1_n_b == $past(chip_sel_in_1_n))
      else $error("control lines not re-driven");
   a_reset_low: assert property (@(posedge clk_sys)
      !arst_n |-> cmd_addr_out_a == '0 && !parity_error_n_oe)
      else $error("outputs not cleared in reset");
   a_par_skip: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !csv_ff && !parity_error_n_oe ##1 !parity_error_n_oe
      ##1 !parity_error_n_oe |-> ##1 !parity_error_n_oe)
      else $error("error raised without select");
endmodule : regbuf_top

// ---- ctrl_model.sv ----
// Controller-side model: drives command/address, selects and parity bit.
// Assumes the bench calls issue() just after a rising edge of clk_sys.
`timescale 1ns/1ps
module ctrl_model (
   input  wire logic                        clk_sys,
   output logic [regbuf_pkg::CA_W-1:0]      cmd_addr_in,
   output logic [3:0]                       select_n,
   output logic                             parity_bit_in
);
   import regbuf_pkg::*;
   logic corrupt;
   initial begin
      cmd_addr_in   = 22'h000000;
      select_n      = 4'hF;
      corrupt       = 1'b0;
      parity_bit_in = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // Parity trails its data by one cycle; corrupt flips it for error tests
   always @(posedge clk_sys) begin
      parity_bit_in <= #1 (^cmd_addr_in) ^ corrupt;
   end
   // Every covered line gets a defined level, never left floating
   task issue(input logic [CA_W-1:0] v, input logic [3:0] s, input logic b);
      cmd_addr_in = v;
      select_n    = s;
      corrupt     = b;
      @(posedge clk_sys);
      #1;
   endtask : issue
endmodule : ctrl_model

// ---- regbuf_top_tb.sv ----
// Self-checking bench for the registered command/address buffer.
// Assumes ctrl_model drives the controller lines, the bench the rest.
`timescale 1ns/1ps
module regbuf_top_tb;
   import regbuf_pkg::*;
   logic            clk_sys = 1'b0;
   logic            arst_n  = 1'b0;
   logic            gate    = 1'b0;
   logic [3:0]      ko      = 4'h0;
   logic [CA_W-1:0] qa, qb, d;
   logic [3:0]      sel_n, sv;
   logic            par, c0a, c0b, c1a, c1b, pe_o, pe_oe;
   logic [1:0]      kea, keb, ota, otb;
   int              err_count = 0;
   int              n_checks  = 0;
   ////////////////////////////////////////////////////////////////////////
   // 100 MHz system clock
   always #5 clk_sys = ~clk_sys;
   ctrl_model ctrl_model_inst (.clk_sys(clk_sys), .cmd_addr_in(d),
      .select_n(sel_n), .parity_bit_in(par));
   regbuf_top regbuf_top_inst (
      .clk_sys(clk_sys), .arst_n(arst_n), .cmd_addr_in(d),
      .chip_sel_in_0_n(sel_n[0]), .chip_sel_in_1_n(sel_n[1]),
      .chip_sel_in_2_n(sel_n[2]), .chip_sel_in_3_n(sel_n[3]),
      .clock_enable_in(ko[3:2]), .termination_ctl_in(ko[1:0]),
      .select_gating_enable(gate), .parity_bit_in(par),
      .cmd_addr_out_a(qa), .cmd_addr_out_b(qb),
      .chip_sel_out_0_n_a(c0a), .chip_sel_out_0_n_b(c0b),
      .chip_sel_out_1_n_a(c1a), .chip_sel_out_1_n_b(c1b),
      .clock_enable_out_a(kea), .clock_enable_out_b(keb),
      .termination_ctl_out_a(ota), .termination_ctl_out_b(otb),
      .parity_error_n_o(pe_o), .parity_error_n_oe(pe_oe));
   ////////////////////////////////////////////////////////////////////////
   task check(input logic [57:0] seen, input logic [57:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %0t outputs %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Both copies of every output, open-drain level always low
   task expect_q(input logic [CA_W-1:0] v, input logic [1:0] s,
                 input logic [3:0] k, input logic e);
      check({qa, qb, c0a, c0b, c1a, c1b, kea, keb, ota, otb, pe_o, pe_oe},
            {v, v, s[0], s[0], s[1], s[1], k[3:2], k[3:2], k[1:0], k[1:0],
             1'b0, e});
   endtask : expect_q
   // Leave reset with quiet inputs; error line must stay released
   task wake;
      arst_n = 1'b1;
      repeat (3) begin
         ctrl_model_inst.issue(22'h000000, 4'h0, 1'b0);
         expect_q(22'h000000, 2'b00, 4'h0, 1'b0);
      end
   endtask : wake
   task summarize;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////////////////
   // Watchdog; the tests need well under a microsecond
   initial begin
      #5000;
      err_count++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      #1;
      expect_q(22'h000000, 2'b00, 4'h0, 1'b0);
      wake();
      $display("test reset done");
      ko = 4'hA;
      ctrl_model_inst.issue(22'h15A5A5, 4'hF, 1'b0);
      expect_q(22'h15A5A5, 2'b11, ko, 1'b0);
      gate = 1'b1;
      ctrl_model_inst.issue(22'h0F0F0F, 4'hF, 1'b0);
      expect_q(22'h15A5A5, 2'b11, ko, 1'b0);
      for (int i = 0; i < 4; i++) begin
         sv = ~(4'h1 << i);
         ctrl_model_inst.issue(22'(i + 1), sv, 1'b0);
         expect_q(22'(i + 1), sv[1:0], ko, 1'b0);
      end
      $display("test update done");
      // Bad parity: selected gated, selected ungated, unselected
      for (int c = 0; c < 3; c++) begin
         gate = (c != 1);
         ctrl_model_inst.issue(22'h000001, (c == 2) ? 4'hF : 4'hE, 1'b1);
         for (int k = 1; k <= 5; k++) begin
            ctrl_model_inst.issue(22'h000001, 4'hF, 1'b0);
            expect_q(22'h000001, 2'b11, ko,
                     c != 2 && (k == 3 || k == 4));
         end
      end
      $display("test parity done");
      ctrl_model_inst.issue(22'h000001, 4'hE, 1'b1);
      repeat (3) ctrl_model_inst.issue(22'h000001, 4'hF, 1'b0);
      expect_q(22'h000001, 2'b11, ko, 1'b1);
      arst_n = 1'b0;
      #1;
      expect_q(22'h000000, 2'b00, 4'h0, 1'b0);
      ctrl_model_inst.issue(22'h3FFFFF, 4'h0, 1'b1);
      expect_q(22'h000000, 2'b00, 4'h0, 1'b0);
      ko = 4'h0;
      ctrl_model_inst.issue(22'h000000, 4'h0, 1'b0);
      wake();
      $display("test midrun reset done");
      summarize();
   end
endmodule : regbuf_top_tb
